// *** logic/eas_pkg.sv ***
// package: register map, field positions and reset values of the status block
package eas_pkg;
   // =====================================================================
   // bus geometry
   localparam int EAS_ADDR_W = 10;
   localparam int EAS_DATA_W = 32;
   localparam int EAS_REG_W = 16;
   localparam int EAS_LANE_LO = 0;
   localparam int EAS_LANE_HI = 1;
   // =====================================================================
   // register map (byte addresses, word aligned)
   localparam logic [9:0] EAS_STATUS_OFS = 10'h0E4;
   localparam logic [9:0] EAS_CTRL_OFS = 10'h0E8;
   // =====================================================================
   // status field positions
   localparam int EAS_RSV15_BIT = 15;
   localparam int EAS_HW_EEE_BIT = 14;
   localparam int EAS_TX_LPI_LATCH_BIT = 13;
   localparam int EAS_TX_LPI_LIVE_BIT = 12;
   localparam int EAS_RX_LPI_LATCH_BIT = 11;
   localparam int EAS_RX_LPI_LIVE_BIT = 10;
   localparam int EAS_RSV9_BIT = 9;
   localparam int EAS_RSV8_BIT = 8;
   localparam int EAS_NP_LOC_ABLE_BIT = 6;
   localparam int EAS_NP_LOC_BIT = 5;
   localparam int EAS_PD_FAULT_BIT = 4;
   localparam int EAS_LP_NP_ABLE_BIT = 3;
   localparam int EAS_NP_ABLE_BIT = 2;
   localparam int EAS_PAGE_RX_BIT = 1;
   localparam int EAS_LP_AN_ABLE_BIT = 0;
   // =====================================================================
   // reset values
   localparam logic EAS_RSV15_RST = 1'h1;
   localparam logic [1:0] EAS_RSV98_RST = 2'h0;
   localparam logic EAS_NP_LOC_ABLE_RST = 1'h1;
   localparam logic EAS_NP_LOC_RST = 1'h1;
   localparam logic EAS_CTRL_FIBER_RST = 1'h0;
   localparam int EAS_CTRL_FIBER_BIT = 0;
   // =====================================================================
   // bus answer states
   typedef enum logic [1:0]
   {
      EAS_IDLE = 2'b00,
      EAS_ACK = 2'b01
   } eas_bus_state_t;
endpackage : eas_pkg

// *** logic/eas_sync2.sv ***
// two-flop synchroniser for one status input
`timescale 1ns/1ps
module eas_sync2
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic d,
   output logic q
);
   logic meta_ff;
   logic sync_ff;
   logic nxt_meta;
   logic nxt_sync;
   // =====================================================================
   // first stage read only by the second
   always_comb
   begin
      nxt_meta = d;
      nxt_sync = meta_ff;
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_ff <= 1'h0;
         sync_ff <= 1'h0;
      end
      else
      begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end
   assign q = sync_ff;
endmodule : eas_sync2

// *** logic/eas_latch_bit.sv ***
// sticky status bit: set wins over clear
`timescale 1ns/1ps
module eas_latch_bit
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic set,
   input wire logic clr,
   output logic q
);
   logic flag_ff;
   logic nxt_flag;
   // =====================================================================
   // event in the clearing cycle is kept
   always_comb
   begin
      nxt_flag = flag_ff;
      if (clr)
      begin
         nxt_flag = 1'h0;
      end
      if (set)
      begin
         nxt_flag = 1'h1;
      end
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         flag_ff <= 1'h0;
      end
      else
      begin
         flag_ff <= nxt_flag;
      end
   end
   assign q = flag_ff;
endmodule : eas_latch_bit

// *** logic/eas_status.sv ***
// eee and auto-negotiation expansion status register with avalon slave
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module eas_status
   import eas_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic [9:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic HW_EEE_EN,
   input wire logic TX_LPI,
   input wire logic RX_LPI,
   input wire logic PD_FAULT,
   input wire logic LP_NP_ABLE,
   input wire logic NP_ABLE,
   input wire logic PAGE_RX,
   input wire logic LP_AN_ABLE
);
   // =====================================================================
   // input synchronisation, one two-flop stage per status pin
   logic s_hw;
   logic s_tx;
   logic s_rx;
   logic s_pd;
   logic s_lpnp;
   logic s_np;
   logic s_pg;
   logic s_lpan;
   eas_sync2 u_sync_hw
   (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .d(HW_EEE_EN),
      .q(s_hw)
   );
   eas_sync2 u_sync_tx
   (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .d(TX_LPI),
      .q(s_tx)
   );
   eas_sync2 u_sync_rx
   (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .d(RX_LPI),
      .q(s_rx)
   );
   eas_sync2 u_sync_pd
   (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .d(PD_FAULT),
      .q(s_pd)
   );
   eas_sync2 u_sync_lpnp
   (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .d(LP_NP_ABLE),
      .q(s_lpnp)
   );
   eas_sync2 u_sync_np
   (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .d(NP_ABLE),
      .q(s_np)
   );
   eas_sync2 u_sync_pg
   (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .d(PAGE_RX),
      .q(s_pg)
   );
   eas_sync2 u_sync_lpan
   (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .d(LP_AN_ABLE),
      .q(s_lpan)
   );
   // =====================================================================
   // bus decode
   eas_bus_state_t state_ff;
   eas_bus_state_t nxt_state;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic wait_ff;
   logic nxt_wait;
   logic fiber_ff;
   logic nxt_fiber;
   logic [31:0] rd_word;
   logic wr_ctrl;
   logic [15:0] status_word;
   logic take;
   logic hit_status;
   logic hit_ctrl;
   logic rd_status;
   logic wr_status;
   logic lo_be;
   logic hi_be;
   logic eee_ok;
   logic tx_latch;
   logic rx_latch;
   logic pd_latch;
   logic pg_latch;
   logic clr_tx;
   logic clr_rx;
   logic pg_prev_ff;
   logic nxt_pg_prev;
   assign take = (AVS_READ || AVS_WRITE) && (state_ff == EAS_IDLE);
   assign hit_status = (AVS_ADDRESS == EAS_STATUS_OFS);
   assign hit_ctrl = (AVS_ADDRESS == EAS_CTRL_OFS);
   assign rd_status = take && AVS_READ && hit_status;
   assign wr_status = take && AVS_WRITE && hit_status;
   assign wr_ctrl = take && AVS_WRITE && hit_ctrl;
   assign lo_be = AVS_BYTEENABLE[EAS_LANE_LO];
   assign hi_be = AVS_BYTEENABLE[EAS_LANE_HI];
   assign eee_ok = !fiber_ff;
   // =====================================================================
   // sticky flags
   // write one to clear, upper byte lane carries bits 13 and 11
   assign clr_tx = wr_status && hi_be &&
                   AVS_WRITEDATA[EAS_TX_LPI_LATCH_BIT];
   assign clr_rx = wr_status && hi_be &&
                   AVS_WRITEDATA[EAS_RX_LPI_LATCH_BIT];
   eas_latch_bit u_tx
   (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .set(s_tx && eee_ok),
      .clr(clr_tx || fiber_ff),
      .q(tx_latch)
   );
   eas_latch_bit u_rx
   (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .set(s_rx && eee_ok),
      .clr(clr_rx || fiber_ff),
      .q(rx_latch)
   );
   eas_latch_bit u_pd
   (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .set(s_pd),
      .clr(rd_status),
      .q(pd_latch)
   );
   // page flag set on a rising edge of the page strobe, read clears it
   eas_latch_bit u_pg
   (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .set(s_pg && !pg_prev_ff),
      .clr(rd_status),
      .q(pg_latch)
   );
   // =====================================================================
   // register image
   always_comb
   begin
      status_word = 16'h0000;
      // reserved bits are constants, so writes cannot reach them
      status_word[EAS_RSV15_BIT] = EAS_RSV15_RST;
      status_word[EAS_HW_EEE_BIT] = s_hw && eee_ok;
      status_word[EAS_TX_LPI_LATCH_BIT] = tx_latch;
      status_word[EAS_TX_LPI_LIVE_BIT] = s_tx && eee_ok;
      status_word[EAS_RX_LPI_LATCH_BIT] = rx_latch;
      status_word[EAS_RX_LPI_LIVE_BIT] = s_rx && eee_ok;
      status_word[EAS_RSV9_BIT] = EAS_RSV98_RST[1];
      status_word[EAS_RSV8_BIT] = EAS_RSV98_RST[0];
      status_word[EAS_NP_LOC_ABLE_BIT] = EAS_NP_LOC_ABLE_RST;
      status_word[EAS_NP_LOC_BIT] = EAS_NP_LOC_RST;
      status_word[EAS_PD_FAULT_BIT] = pd_latch;
      status_word[EAS_LP_NP_ABLE_BIT] = s_lpnp;
      status_word[EAS_NP_ABLE_BIT] = s_np;
      status_word[EAS_PAGE_RX_BIT] = pg_latch;
      status_word[EAS_LP_AN_ABLE_BIT] = s_lpan;
   end
   // =====================================================================
   // read mux, unmapped addresses read as zero
   always_comb
   begin
      rd_word = 32'h0000_0000;
      case (AVS_ADDRESS)
         EAS_STATUS_OFS:
         begin
            rd_word = {16'h0000, status_word};
         end
         EAS_CTRL_OFS:
         begin
            rd_word[EAS_CTRL_FIBER_BIT] = fiber_ff;
         end
         default:
         begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end
   // =====================================================================
   // bus state and read data
   // one wait cycle keeps readdata registered and decoupled from the decode
   always_comb
   begin
      nxt_state = state_ff;
      nxt_rdata = rdata_ff;
      nxt_wait = 1'h1;
      case (state_ff)
         EAS_IDLE:
         begin
            if (take)
            begin
               nxt_state = EAS_ACK;
               nxt_wait = 1'h0;
               nxt_rdata = 32'h0000_0000;
               // writes leave read data at zero
               if (AVS_READ)
               begin
                  nxt_rdata = rd_word;
               end
            end
         end
         EAS_ACK:
         begin
            nxt_state = EAS_IDLE;
            nxt_wait = 1'h1;
         end
         default:
         begin
            nxt_state = EAS_IDLE;
         end
      endcase
   end
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state_ff <= EAS_IDLE;
         rdata_ff <= 32'h0000_0000;
         wait_ff <= 1'h1;
      end
      else
      begin
         state_ff <= nxt_state;
         rdata_ff <= nxt_rdata;
         wait_ff <= nxt_wait;
      end
   end
   // =====================================================================
   // mode control, lane 0 carries the fiber bit
   always_comb
   begin
      nxt_fiber = fiber_ff;
      if (wr_ctrl && lo_be)
      begin
         nxt_fiber = AVS_WRITEDATA[EAS_CTRL_FIBER_BIT];
      end
   end
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         fiber_ff <= EAS_CTRL_FIBER_RST;
      end
      else
      begin
         fiber_ff <= nxt_fiber;
      end
   end
   // =====================================================================
   // page strobe edge detect, idle low so reset gives no false edge
   always_comb
   begin
      nxt_pg_prev = s_pg;
   end
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         pg_prev_ff <= 1'h0;
      end
      else
      begin
         pg_prev_ff <= nxt_pg_prev;
      end
   end
   assign AVS_READDATA = rdata_ff;
   assign AVS_WAITREQUEST = wait_ff;
endmodule : eas_status

// *** tb/eas_status_checker.sv ***
// checker: bus handshake and status bit relations
`timescale 1ns/1ps
module eas_status_checker
   import eas_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic [9:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic HW_EEE_EN,
   input wire logic TX_LPI,
   input wire logic RX_LPI,
   input wire logic PD_FAULT,
   input wire logic LP_NP_ABLE,
   input wire logic NP_ABLE,
   input wire logic LP_AN_ABLE
);
   // ==========
   // input history: four samples cover the two-flop lag
   logic [6:0] h1_ff, h2_ff, h3_ff, h4_ff;
   logic rd_ff, fib_ff;
   wire [6:0] in_now = {HW_EEE_EN, TX_LPI, RX_LPI, PD_FAULT, LP_NP_ABLE,
      NP_ABLE, LP_AN_ABLE};
   wire [6:0] st = (h1_ff & h2_ff & h3_ff & h4_ff) |
      ~(h1_ff | h2_ff | h3_ff | h4_ff);
   wire ack = rd_ff && !AVS_WAITREQUEST;
   wire [15:0] rv = AVS_READDATA[15:0];
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         {h1_ff, h2_ff, h3_ff, h4_ff} <= '0;
         rd_ff <= 1'h0;
         fib_ff <= 1'h0;
      end
      else
      begin
         {h1_ff, h2_ff, h3_ff, h4_ff} <= {in_now, h1_ff, h2_ff, h3_ff};
         rd_ff <= AVS_READ && AVS_WAITREQUEST &&
            AVS_ADDRESS == EAS_STATUS_OFS;
         if (AVS_WRITE && AVS_WAITREQUEST && AVS_ADDRESS == EAS_CTRL_OFS)
            fib_ff <= AVS_WRITEDATA[0];
      end
   end
   // ==========
   // assertions
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_B);
   take_ack_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
      |=> !AVS_WAITREQUEST) else $error("request not answered");
   ack_single_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("answer longer than one cycle");
   no_spur_a: assert property (!AVS_READ && !AVS_WRITE && AVS_WAITREQUEST
      |=> AVS_WAITREQUEST) else $error("answer without request");
   fixed_bits_a: assert property (ack |->
      AVS_READDATA[31:16] == 16'h0 && rv[15] && rv[9:5] == 5'h03)
      else $error("fixed bits wrong");
   fiber_mask_a: assert property (ack && fib_ff |-> rv[14:10] == 5'h0)
      else $error("eee bits shown in fiber mode");
   hw_eee_a: assert property (ack && !fib_ff && st[6]
      |-> rv[14] == h1_ff[6]) else $error("hw eee bit wrong");
   live_lpi_a: assert property (ack && !fib_ff && st[5] && st[4]
      |-> rv[12] == h1_ff[5] && rv[10] == h1_ff[4]) else $error("live lpi");
   lpi_latch_a: assert property (ack && !fib_ff
      && &(st[5:4] & h1_ff[5:4]) |-> rv[13] && rv[11])
      else $error("lpi latch not set");
   pd_fault_a: assert property (ack && st[3] && h1_ff[3] |-> rv[4])
      else $error("fault latch not set");
   ro_inputs_a: assert property (ack && &st[2:0]
      |-> {rv[3:2], rv[0]} == h1_ff[2:0]) else $error("ability bits");
endmodule : eas_status_checker
bind eas_status eas_status_checker i_chk (.REF_CLK(REF_CLK), .RST_B(RST_B),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .HW_EEE_EN(HW_EEE_EN),
   .TX_LPI(TX_LPI), .RX_LPI(RX_LPI), .PD_FAULT(PD_FAULT),
   .LP_NP_ABLE(LP_NP_ABLE), .NP_ABLE(NP_ABLE), .LP_AN_ABLE(LP_AN_ABLE));

// *** tb/eee_an_expansion_status_test.sv ***
// testbench: register accesses against the status bits
`timescale 1ns/1ps
module eee_an_expansion_status_test
   import eas_pkg::*;
;
   // ==========
   // stimulus signals
   logic REF_CLK = 1'h0, RST_B = 1'h0, AVS_READ = 1'h0, AVS_WRITE = 1'h0;
   logic [9:0] AVS_ADDRESS = 10'h0;
   logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA;
   logic [3:0] AVS_BYTEENABLE = 4'h3;
   logic AVS_WAITREQUEST;
   logic [7:0] st_in = 8'h0;
   int err_count = 0, total_checks = 0, cycles = 0;
   eas_status i_dut (.REF_CLK(REF_CLK), .RST_B(RST_B),
      .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .HW_EEE_EN(st_in[7]), .TX_LPI(st_in[6]), .RX_LPI(st_in[5]),
      .PD_FAULT(st_in[4]), .LP_NP_ABLE(st_in[3]), .NP_ABLE(st_in[2]),
      .PAGE_RX(st_in[1]), .LP_AN_ABLE(st_in[0]));
   initial
      forever #2.5 REF_CLK = ~REF_CLK;
   // ==========
   // hang guard: the sequence needs about 115 cycles
   always @(posedge REF_CLK)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         err_count++;
         tally_and_finish();
      end
   end
   // ==========
   // tasks
   task automatic tally_and_finish();
      if (err_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] seen, exp, input string nm);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one access; an idle edge follows so requests never touch
   task automatic bus(input logic wr, input logic [9:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= wd;
      AVS_READ <= !wr;
      AVS_WRITE <= wr;
      do
         @(posedge REF_CLK);
      while (AVS_WAITREQUEST !== 1'h0);
      rd = AVS_READDATA;
      AVS_READ <= 1'h0;
      AVS_WRITE <= 1'h0;
      @(posedge REF_CLK);
   endtask : bus
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp,
      input string nm);
      logic [31:0] d;
      bus(1'h0, a, 32'h0, d);
      chk(d, exp, nm);
   endtask : rd_chk
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'h1, a, d, x);
   endtask : wr
   // inputs pass two flops, so let them settle
   task automatic set_in(input logic [7:0] v);
      st_in <= v;
      repeat (5) @(posedge REF_CLK);
   endtask : set_in
   // ==========
   // main sequence
   initial
   begin
      repeat (4) @(posedge REF_CLK);
      RST_B <= 1'h1;
      @(posedge REF_CLK);
      rd_chk(EAS_STATUS_OFS, 32'h8060, "reset");
      rd_chk(10'h0EC, 32'h0, "unmapped");
      AVS_BYTEENABLE <= 4'hF;
      wr(10'h0EC, 32'hFFFF);
      wr(EAS_STATUS_OFS, 32'h7F9F);
      AVS_BYTEENABLE <= 4'h3;
      rd_chk(EAS_STATUS_OFS, 32'h8060, "ro write");
      set_in(8'hED);
      rd_chk(EAS_STATUS_OFS, 32'hFC6D, "all set");
      set_in(8'h8D);
      rd_chk(EAS_STATUS_OFS, 32'hE86D, "lpi gone");
      rd_chk(EAS_STATUS_OFS, 32'hE86D, "lpi held");
      wr(EAS_STATUS_OFS, 32'h2000);
      rd_chk(EAS_STATUS_OFS, 32'hC86D, "tx clear");
      wr(EAS_STATUS_OFS, 32'h0800);
      rd_chk(EAS_STATUS_OFS, 32'hC06D, "rx clear");
      set_in(8'h9F);
      set_in(8'h8D);
      rd_chk(EAS_STATUS_OFS, 32'hC07F, "fault");
      rd_chk(EAS_STATUS_OFS, 32'hC06D, "read clear");
      wr(EAS_CTRL_OFS, 32'h1);
      rd_chk(EAS_CTRL_OFS, 32'h1, "fiber");
      set_in(8'hED);
      rd_chk(EAS_STATUS_OFS, 32'h806D, "fiber mask");
      set_in(8'h8D);
      wr(EAS_CTRL_OFS, 32'h0);
      rd_chk(EAS_STATUS_OFS, 32'hC06D, "copper");
      set_in(8'h49);
      rd_chk(EAS_STATUS_OFS, 32'hB069, "tx only");
      set_in(8'h24);
      rd_chk(EAS_STATUS_OFS, 32'hAC64, "rx only");
      wr(EAS_STATUS_OFS, 32'h2800);
      rd_chk(EAS_STATUS_OFS, 32'h8C64, "set wins");
      tally_and_finish();
   end
endmodule : eee_an_expansion_status_test
